// >>> jump_link_register_unit.sv
// Register-indirect jump-and-link unit with optional hazard barrier.
// Assumes a pipeline that supplies the target register value with the issued
// word, reports delay-slot completion and older system-state writes in flight.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "jlr_cfg.svh"

// Functional notes
// [RULE1] Link register receives the jump's own PC plus 8.
// [RULE2] Assemblers encode link register 31 when none is written.
// [RULE3] Read target and write link in jump slot; redirect after delay slot.
// [RULE4] Without compact set, PC takes the whole target value.
// [RULE5] With compact set, bit 0 goes to mode bit; PC bit 0 zero.
// [RULE6] Target bit 0 set never raises an address exception by itself; without compact set, the code flags it as an address error.
// [RULE7] Software must not use equal target and link register fields.
// [RULE8] Without compact set, nonzero low two target bits flag address error.
// [RULE9] With compact set, bit 0 zero and bit 1 one flag address error.
// [RULE10] Software supplies targets aligned for the chosen instruction set.
// [RULE11] Hint zero is default; hint bit 10 selects the barrier form.
// [RULE12] Decode opcode 000000, bits 20..16 zero, function 001001.
// [RULE13] Barrier form clears execution and instruction hazards before target fetch.
// [RULE14] Barrier form works in every mode, no coprocessor access needed.
// [RULE15] Only hazards from instructions before the jump are cleared.
// [RULE16] Software keeps branches, jumps, returns and waits out of the slot.
// [RULE17] Software clears instruction hazards after remapping or writing code.
// [RULE18] Hold target fetch until earlier system writes commit, then refetch.
module jump_link_register_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt
  output logic irq_o,
  // Issue from decode stage
  input jlr_pkg::jl_issue_t issue_i,
  output logic issue_ready_o,
  output logic [4:0] tgt_rd_idx_o,
  // Pipeline progress
  input wire logic slot_done_i,
  input wire logic older_wr_busy_i,
  // Results
  output jlr_pkg::link_wr_t link_o,
  output jlr_pkg::redirect_t redir_o,
  output logic fetch_hold_o,
  output logic isa_select_bit_o
);
  import jlr_pkg::*;

  jl_regs_t r;
  jl_regs_t next_r;
  jl_dec_t dec;

  logic bus_req;
  logic bus_wr;
  logic take;
  logic ca;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [`JL_XLEN-1:0] tgt_pc;
  logic tgt_isa;
  logic tgt_aerr;

  jlr_decode u_decode (
    .instr_i(issue_i.instr),
    .dec_o(dec)
  );

  always_comb begin
    bus_req = cyc_i & stb_i;
    bus_wr = bus_req & r.ack & we_i & sel_i[0];
    ca = r.ctrl[`JL_CTRL_CA];
    // No privilege input: barrier form is taken in any operating mode
    take = issue_i.valid & (r.state == ST_IDLE) & dec.hit
      & r.ctrl[`JL_CTRL_EN]; // [RULE14]

    // Target conversion at redirect time
    if (ca) begin
      tgt_pc = {r.target[`JL_XLEN-1:1], 1'b0}; // [RULE5] [RULE6]
      tgt_isa = r.target[0]; // [RULE5]
      tgt_aerr = ~r.target[0] & r.target[1]; // [RULE9]
    end else begin
      tgt_pc = r.target; // [RULE4]
      tgt_isa = r.isa;
      tgt_aerr = |r.target[1:0]; // [RULE8]
    end
  end

  always_comb begin
    next_r = r;
    next_r.link.we = 1'b0;
    next_r.redir.valid = 1'b0;
    next_r.ack = 1'b0;
    ev = 3'h0;
    clr = 3'h0;

    // Bus answer one cycle after the request is seen
    if (bus_req & ~r.ack) begin
      next_r.ack = 1'b1;
      unique case (adr_i)
        `JL_REG_CTRL: next_r.dat = {30'h0, r.ctrl};
        `JL_REG_STATUS: next_r.dat = {29'h0, r.status};
        `JL_REG_MASK: next_r.dat = {29'h0, r.mask};
        `JL_REG_STATE: next_r.dat = {28'h0, r.barrier, r.isa, r.state};
        `JL_REG_LAST_TGT: next_r.dat = r.target;
        default: next_r.dat = 32'h0;
      endcase
    end

    // Writes land on the edge that completes the cycle
    if (bus_wr) begin
      unique case (adr_i)
        `JL_REG_CTRL: next_r.ctrl = dat_i[1:0];
        `JL_REG_STATUS: clr = dat_i[2:0];
        `JL_REG_MASK: next_r.mask = dat_i[2:0];
        default: next_r.ctrl = r.ctrl;
      endcase
    end

    unique case (r.state)
      ST_IDLE: begin
        if (take) begin
          // Target captured and link written in the jump's own slot
          next_r.target = issue_i.target; // [RULE3]
          next_r.barrier = dec.barrier; // [RULE13]
          next_r.link.we = 1'b1; // [RULE3]
          next_r.link.idx = dec.link_idx;
          next_r.link.data = issue_i.pc + `JL_LINK_OFFSET; // [RULE1]
          next_r.state = ST_SLOT;
        end
      end
      ST_SLOT: begin
        // Delay-slot instruction finishes before control moves
        if (slot_done_i) begin // [RULE3]
          // Slot's own writes are not waited for, only older ones
          next_r.state = dec_barrier_wait(r.barrier, older_wr_busy_i); // [RULE15]
        end
      end
      ST_DRAIN: begin
        // Target fetch held until earlier system writes commit
        if (~older_wr_busy_i) begin // [RULE18] [RULE13]
          next_r.state = ST_REDIR;
        end
      end
      ST_REDIR: begin
        next_r.redir.valid = 1'b1; // [RULE3]
        next_r.redir.pc = tgt_pc;
        next_r.redir.isa = tgt_isa;
        next_r.redir.addr_err = tgt_aerr; // [RULE8] [RULE9]
        next_r.redir.barrier = r.barrier; // [RULE18]
        next_r.isa = tgt_isa; // [RULE5]
        ev[`JL_ST_JUMP] = 1'b1;
        ev[`JL_ST_AERR] = tgt_aerr;
        ev[`JL_ST_BAR] = r.barrier;
        next_r.state = ST_IDLE;
      end
    endcase

    // Set wins over a simultaneous write-one clear
    next_r.status = (r.status & ~clr) | ev;
  end

  // Barrier form waits for older writes; plain form goes straight on
  function automatic jl_state_t dec_barrier_wait(input logic bar, input logic busy);
    if (bar & busy) begin
      return ST_DRAIN;
    end
    return ST_REDIR;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.ctrl <= `JL_CTRL_RST;
      r.status <= `JL_ST_RST;
      r.mask <= `JL_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign dat_o = r.dat;
  assign ack_o = r.ack;
  assign irq_o = |(r.status & r.mask);
  assign issue_ready_o = (r.state == ST_IDLE);
  assign tgt_rd_idx_o = dec.tgt_idx;
  assign link_o = r.link;
  assign redir_o = r.redir;
  assign fetch_hold_o = (r.state == ST_DRAIN);
  assign isa_select_bit_o = r.isa;

endmodule

// >>> jlr_cfg.svh
// Constants of the register-indirect jump-and-link unit: fields, codes, offsets.
// Assumes inclusion by bare name from the package and the design files.
`ifndef JLR_CFG_SVH
`define JLR_CFG_SVH

// Datapath
`define JL_XLEN 32
`define JL_LINK_OFFSET 32'h0000_0008

// Instruction field positions
`define JL_OPC_HI 31
`define JL_OPC_LO 26
`define JL_TGT_HI 25
`define JL_TGT_LO 21
`define JL_ZRO_HI 20
`define JL_ZRO_LO 16
`define JL_LNK_HI 15
`define JL_LNK_LO 11
`define JL_HINT_HI 10
`define JL_HINT_LO 6
`define JL_FN_HI 5
`define JL_FN_LO 0
`define JL_BARRIER_BIT 10

// Instruction codes
`define JL_OPC_SPECIAL 6'h00
`define JL_FN_JLR 6'h09
`define JL_ZERO_FIELD 5'h00
`define JL_HINT_DEFAULT 5'h00
`define JL_DEFAULT_LINK_REG 5'h1f

// Register byte offsets
`define JL_REG_CTRL 5'h00
`define JL_REG_STATUS 5'h04
`define JL_REG_MASK 5'h08
`define JL_REG_STATE 5'h0c
`define JL_REG_LAST_TGT 5'h10

// Control fields
`define JL_CTRL_EN 0
`define JL_CTRL_CA 1
`define JL_CTRL_RST 2'h1

// Status and mask fields
`define JL_ST_JUMP 0
`define JL_ST_AERR 1
`define JL_ST_BAR 2
`define JL_ST_RST 3'h0
`define JL_MASK_RST 3'h0

`endif

// >>> jlr_pkg.sv
// Types shared by the jump-and-link unit and its decoder.
// Assumes jlr_cfg.svh is on the include path.
`include "jlr_cfg.svh"

package jlr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SLOT  = 2'b01,
    ST_DRAIN = 2'b11,
    ST_REDIR = 2'b10
  } jl_state_t;

  typedef struct packed {
    logic valid;
    logic [`JL_XLEN-1:0] instr;
    logic [`JL_XLEN-1:0] pc;
    logic [`JL_XLEN-1:0] target;
  } jl_issue_t;

  typedef struct packed {
    logic hit;
    logic barrier;
    logic [4:0] tgt_idx;
    logic [4:0] link_idx;
  } jl_dec_t;

  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [`JL_XLEN-1:0] data;
  } link_wr_t;

  typedef struct packed {
    logic valid;
    logic [`JL_XLEN-1:0] pc;
    logic isa;
    logic addr_err;
    logic barrier;
  } redirect_t;

  typedef struct packed {
    jl_state_t state;
    logic [1:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [`JL_XLEN-1:0] target;
    logic barrier;
    logic isa;
    link_wr_t link;
    redirect_t redir;
    logic ack;
    logic [`JL_XLEN-1:0] dat;
  } jl_regs_t;

endpackage

// >>> jlr_decode.sv
// Decoder for the register-indirect jump-and-link word and its barrier form.
// Assumes a 32-bit instruction word; purely combinational.
`timescale 1ns/1ps
`include "jlr_cfg.svh"

module jlr_decode (
  // Instruction word
  input wire logic [`JL_XLEN-1:0] instr_i,
  // Decoded fields
  output jlr_pkg::jl_dec_t dec_o
);
  import jlr_pkg::*;

  logic [4:0] hint;
  logic legal_hint;

  always_comb begin
    hint = instr_i[`JL_HINT_HI:`JL_HINT_LO];
    // Zero is default handling, top hint bit asks for the barrier
    legal_hint = (hint == `JL_HINT_DEFAULT) | instr_i[`JL_BARRIER_BIT]; // [RULE11]
    dec_o.hit = (instr_i[`JL_OPC_HI:`JL_OPC_LO] == `JL_OPC_SPECIAL)
      & (instr_i[`JL_ZRO_HI:`JL_ZRO_LO] == `JL_ZERO_FIELD)
      & (instr_i[`JL_FN_HI:`JL_FN_LO] == `JL_FN_JLR)
      & legal_hint; // [RULE12]
    dec_o.barrier = instr_i[`JL_BARRIER_BIT]; // [RULE11]
    dec_o.tgt_idx = instr_i[`JL_TGT_HI:`JL_TGT_LO];
    dec_o.link_idx = instr_i[`JL_LNK_HI:`JL_LNK_LO];
  end

endmodule

// >>> jlr_chk.sv
// Port checker of the jump-and-link unit.
// Assumes binding into every unit instance.
`timescale 1ns/1ps
module jlr_chk (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Pipeline side
  input jlr_pkg::jl_issue_t issue_i,
  input wire logic issue_ready_o,
  input wire logic [4:0] tgt_rd_idx_o,
  input jlr_pkg::link_wr_t link_o,
  input jlr_pkg::redirect_t redir_o,
  input wire logic fetch_hold_o
);
  import jlr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ld; link_o.we |-> link_o.data == $past(issue_i.pc) + 32'h8; endproperty
  a_ld: assert property (p_ld) else $error("link data");
  property p_li; link_o.we |-> link_o.idx == $past(issue_i.instr[15:11]); endproperty
  a_li: assert property (p_li) else $error("link index");
  property p_tg; issue_i.valid |-> tgt_rd_idx_o == issue_i.instr[25:21]; endproperty
  a_tg: assert property (p_tg) else $error("target index");
  property p_sl; link_o.we |-> !issue_ready_o ##1 !redir_o.valid; endproperty
  a_sl: assert property (p_sl) else $error("early redirect");
  property p_rd; redir_o.valid |-> issue_ready_o ##1 !redir_o.valid; endproperty
  a_rd: assert property (p_rd) else $error("redirect pulse");
  property p_hd; fetch_hold_o |-> !redir_o.valid; endproperty
  a_hd: assert property (p_hd) else $error("redirect in hold");
  property p_al; redir_o.valid && redir_o.pc[1:0] == 2'b00 |-> !redir_o.addr_err; endproperty
  a_al: assert property (p_al) else $error("aligned error");
  property p_ak; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ak: assert property (p_ak) else $error("bus ack");
endmodule

bind jump_link_register_unit jlr_chk jlr_chk_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .issue_i, .issue_ready_o, .tgt_rd_idx_o, .link_o, .redir_o, .fetch_hold_o);

// >>> pipe_model.sv
// Pipeline model feeding jump words and delay-slot progress.
// Assumes one jump at a time, launched by go_i.
`timescale 1ns/1ps
module pipe_model (
  // Clock, reset, commands
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [31:0] word_i,
  input wire logic [31:0] tgt_i,
  input wire logic [3:0] busy_i,
  // Unit side
  input wire logic ready_i,
  input wire logic link_we_i,
  output jlr_pkg::jl_issue_t issue_o,
  output logic slot_done_o,
  output logic busy_o
);
  import jlr_pkg::*;
  logic [3:0] cnt;
  assign busy_o = cnt != 4'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      issue_o <= '0;
      slot_done_o <= 1'b0;
      cnt <= 4'h0;
    end else begin
      // Slot holds a plain instruction, done one cycle on
      slot_done_o <= link_we_i;
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      if (go_i) begin
        issue_o <= {1'b1, word_i, 32'h0000_0100, tgt_i};
        cnt <= busy_i;
      end else if (issue_o.valid && ready_i) begin
        // Released word shows its inverse
        issue_o <= ~issue_o;
      end
    end
  end
endmodule

// >>> testbench.sv
// Self-checking bench of the jump-and-link unit.
// Assumes unit, checker and pipeline model compiled first.
`timescale 1ns/1ps
module testbench;
  import jlr_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, go, ack_o, irq_o, issue_ready_o, slot, wbusy;
  logic fetch_hold_o, isa_select_bit_o;
  logic [3:0] busy;
  logic [4:0] adr, tgt_rd_idx_o;
  logic [31:0] dat, word, tgt, dat_o;
  jl_issue_t issue;
  link_wr_t link_o;
  redirect_t redir_o;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  jump_link_register_unit jump_link_register_unit_inst (.clk_i, .rst_i, .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o, .ack_o, .irq_o,
    .issue_i(issue), .issue_ready_o, .tgt_rd_idx_o, .slot_done_i(slot),
    .older_wr_busy_i(wbusy), .link_o, .redir_o, .fetch_hold_o, .isa_select_bit_o);
  pipe_model pipe_model_inst (.clk_i, .rst_i, .go_i(go), .word_i(word), .tgt_i(tgt),
    .busy_i(busy), .ready_i(issue_ready_o), .link_we_i(link_o.we), .issue_o(issue),
    .slot_done_o(slot), .busy_o(wbusy));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task print_verdict;
    $display("comparisons %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      print_verdict;
    end
  end
  task chk(input logic c, input string m);
    comparisons++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  function automatic logic [31:0] w(input logic [4:0] tgt_field, link_field, hint);
    return {6'h00, tgt_field, 5'h00, link_field, hint, 6'h09};
  endfunction
  task wb(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task jmp(input logic [31:0] wd, t, input logic ca, input logic [3:0] bz,
      input logic [31:0] ep, input logic ei, ee, eb);
    int n;
    logic hold;
    logic [31:0] q;
    wb(1'b1, 5'h00, {30'h0, ca, 1'b1}, q);
    @(posedge clk_i);
    go <= 1'b1;
    word <= wd;
    tgt <= t;
    busy <= bz;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    hold = 1'b0;
    while (link_o.we !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    chk(link_o.we === 1'b1 && link_o.idx === wd[15:11] && link_o.data === 32'h108,
      "link");
    while (redir_o.valid !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
      hold |= fetch_hold_o;
    end
    chk(redir_o.valid === 1'b1 && redir_o.pc === ep && redir_o.isa === ei, "target");
    chk(redir_o.addr_err === ee, "address error");
    chk(redir_o.barrier === eb && hold === (eb && bz != 4'h0), "barrier");
  endtask
  task t_regs;
    logic [4:0] a [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14};
    logic [31:0] q;
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0, q);
      chk(q === (i == 0 ? 32'h1 : 32'h0), "reset value");
    end
    $display("regs done");
  endtask
  task t_plain;
    jmp(w(5'd3, 5'd5, 5'h00), 32'h2000, 1'b0, 4'h8, 32'h2000, 1'b0, 1'b0, 1'b0);
    jmp(w(5'd3, 5'd5, 5'h00), 32'h2002, 1'b0, 4'h0, 32'h2002, 1'b0, 1'b1, 1'b0);
    $display("plain done");
  endtask
  task t_compact;
    jmp(w(5'd4, 5'd6, 5'h00), 32'h3001, 1'b1, 4'h0, 32'h3000, 1'b1, 1'b0, 1'b0);
    jmp(w(5'd4, 5'd6, 5'h00), 32'h3002, 1'b1, 4'h0, 32'h3002, 1'b0, 1'b1, 1'b0);
    jmp(w(5'd4, 5'd6, 5'h00), 32'h3003, 1'b1, 4'h0, 32'h3002, 1'b1, 1'b0, 1'b0);
    @(posedge clk_i);
    chk(isa_select_bit_o === 1'b1, "mode bit");
    $display("compact done");
  endtask
  task t_barrier;
    jmp(w(5'd7, 5'd31, 5'h10), 32'h4000, 1'b0, 4'h8, 32'h4000, 1'b1, 1'b0, 1'b1);
    jmp(w(5'd7, 5'd31, 5'h13), 32'h4004, 1'b0, 4'h0, 32'h4004, 1'b1, 1'b0, 1'b1);
    $display("barrier done");
  endtask
  task t_nohit;
    logic seen;
    for (int i = 0; i < 3; i++) begin
      seen = 1'b0;
      @(posedge clk_i);
      go <= 1'b1;
      word <= i == 0 ? w(5'd3, 5'd5, 5'h00) | 32'h0001_0000
        : i == 1 ? w(5'd3, 5'd5, 5'h00) ^ 32'h1 : w(5'd3, 5'd5, 5'h01);
      @(posedge clk_i);
      go <= 1'b0;
      repeat (8) begin
        @(posedge clk_i);
        seen |= link_o.we | redir_o.valid;
      end
      chk(seen === 1'b0 && issue_ready_o === 1'b1, "foreign word");
    end
    $display("nohit done");
  endtask
  task t_irq;
    logic [31:0] q;
    wb(1'b1, 5'h04, 32'h7, q);
    wb(1'b1, 5'h08, 32'h1, q);
    jmp(w(5'd2, 5'd31, 5'h10), 32'h6000, 1'b0, 4'h0, 32'h6000, 1'b1, 1'b0, 1'b1);
    wb(1'b0, 5'h04, 32'h0, q);
    chk(q === 32'h5 && irq_o === 1'b1, "status set");
    wb(1'b1, 5'h04, 32'h1, q);
    wb(1'b0, 5'h04, 32'h0, q);
    chk(q === 32'h4 && irq_o === 1'b0, "status clear");
    wb(1'b1, 5'h08, 32'h4, q);
    wb(1'b0, 5'h08, 32'h0, q);
    chk(q === 32'h4 && irq_o === 1'b1, "mask");
    $display("irq done");
  endtask
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, go, adr, dat, word, tgt, busy} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_plain;
    t_compact;
    t_barrier;
    t_nohit;
    t_irq;
    print_verdict;
  end
endmodule
